// ==== verilog/tlec_pkg.sv ====
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// [RQ1] forward run uses forward ceiling, reverse run uses reverse ceiling
// [RQ2] ceilings are tenths of a percent of rated torque, at most 500.0%
// [RQ3] in sensorless vector mode a ceiling below 50.0% becomes 50.0%
// [RQ4] release ceilings count only when brake control select is 2
// [RQ5] release ceilings hold during brake release time after start, then normal ones
// [RQ6] encoder line count 0 to 8192, default 1024
// [RQ7] encoder kind: 0 quadrature, 1 commutation, 2 resolver, 3 and 4 reserved
// [RQ8] phase order setting is honoured only for encoder kind 0
// [RQ9] auto-tuning finds the quadrature phase order and writes it back
// [RQ10] loss check enable 1 reports encoder loss as error 20, 0 suppresses it
// [RQ11] software must set line count to the real encoder before closed-loop running
// [RQ12] motor control select: 0 sensorless, 1 closed loop, 2 voltage per frequency
// [RQ13] encoder loss error stays set until a fault reset; the code also clears it on a status write with bit 0 set
package tlec_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MOTOR_CONTROL_SELECT     = 8'h00;
    localparam logic [7:0] ADDR_FWD_CEILING              = 8'h04;
    localparam logic [7:0] ADDR_REV_CEILING              = 8'h08;
    localparam logic [7:0] ADDR_FWD_REL_CEILING          = 8'h0c;
    localparam logic [7:0] ADDR_REV_REL_CEILING          = 8'h10;
    localparam logic [7:0] ADDR_BRAKE_CONTROL_SELECT     = 8'h14;
    localparam logic [7:0] ADDR_BRAKE_RELEASE_TIME       = 8'h18;
    localparam logic [7:0] ADDR_ENCODER_LINE_COUNT       = 8'h1c;
    localparam logic [7:0] ADDR_ENCODER_KIND_SELECT      = 8'h20;
    localparam logic [7:0] ADDR_QUAD_PHASE_ORDER         = 8'h24;
    localparam logic [7:0] ADDR_ENCODER_LOSS_CHECK       = 8'h28;
    localparam logic [7:0] ADDR_STATUS                   = 8'h2c;

    // ------------------------------------------------------------
    // field positions of the status word
    // ------------------------------------------------------------
    localparam int STAT_LOSS_BIT    = 0;
    localparam int STAT_RELEASE_BIT = 1;
    localparam int STAT_PHASE_BIT   = 2;
    localparam int STAT_CEIL_LSB    = 16;

    // ------------------------------------------------------------
    // values and reset values
    // ------------------------------------------------------------
    localparam logic [12:0] CEIL_MAX          = 13'h1388;
    localparam logic [12:0] SVC_FLOOR         = 13'h01f4;
    localparam logic [12:0] RST_FWD_CEIL      = 13'h0708;
    localparam logic [12:0] RST_REV_CEIL      = 13'h0708;
    localparam logic [12:0] RST_FWD_REL_CEIL  = 13'h05dc;
    localparam logic [12:0] RST_REV_REL_CEIL  = 13'h0514;
    localparam logic [13:0] LINE_COUNT_MAX    = 14'h2000;
    localparam logic [13:0] RST_LINE_COUNT    = 14'h0400;
    localparam logic [1:0]  MODE_SENSORLESS   = 2'h0;
    localparam logic [1:0]  MODE_CLOSED_LOOP  = 2'h1;
    localparam logic [1:0]  MODE_VF           = 2'h2;
    localparam logic [2:0]  BRAKE_MANUAL      = 3'h2;
    localparam logic [2:0]  RST_BRAKE_SELECT  = 3'h0;
    localparam logic [15:0] RST_BRAKE_TIME    = 16'h0000;
    localparam logic [2:0]  KIND_QUADRATURE   = 3'h0;
    localparam logic [2:0]  KIND_COMMUTATION  = 3'h1;
    localparam logic [2:0]  KIND_RESOLVER     = 3'h2;
    localparam logic [2:0]  KIND_MAX          = 3'h4;
    localparam logic [7:0]  ERR_ENCODER_LOSS  = 8'h14;

    // brake release time counts in milliseconds
    localparam int CLK_MHZ            = 200;
    localparam int BRAKE_TIME_UNIT_US = 1000;
    localparam int BRAKE_UNIT_CYCLES  = BRAKE_TIME_UNIT_US * CLK_MHZ;

    typedef logic [12:0] tlec_ceil_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] brake_sel;
        tlec_ceil_t fwd;
        tlec_ceil_t rev;
        tlec_ceil_t fwd_rel;
        tlec_ceil_t rev_rel;
    } tlec_torque_cfg_t;

    typedef struct packed {
        logic [13:0] line_count;
        logic        kind_quadrature;
        logic        kind_commutation;
        logic        kind_resolver;
        logic        kind_reserved;
        logic        phase_order;
    } tlec_enc_cfg_t;

    typedef struct packed {
        logic sensorless;
        logic closed_loop;
        logic vf;
    } tlec_mode_t;

    function automatic tlec_ceil_t tlec_clamp_ceiling(input logic [31:0] w);
        if (w > 32'(CEIL_MAX)) begin
            return CEIL_MAX;
        end
        return w[12:0];
    endfunction

    function automatic tlec_ceil_t tlec_floor(input tlec_ceil_t c, input logic [1:0] mode);
        if (mode == MODE_SENSORLESS && c < SVC_FLOOR) begin
            return SVC_FLOOR;
        end
        return c;
    endfunction

endpackage

// ==== verilog/tlec_ceiling_sel.sv ====
`timescale 1ns/10ps
module tlec_ceiling_sel (
    input  tlec_pkg::tlec_torque_cfg_t cfg,
    input  wire logic                  run_fwd,
    input  wire logic                  run_rev,
    input  wire logic                  release_active,
    output tlec_pkg::tlec_ceil_t       ceiling
);

    // ------------------------------------------------------------
    // ceiling choice
    // ------------------------------------------------------------
    // both or neither direction requested means no run, so no torque
    always_comb begin
        ceiling = '0;
        if (run_fwd && !run_rev) begin
            if (release_active) begin
                ceiling = tlec_pkg::tlec_floor(cfg.fwd_rel, cfg.mode); // RQ5 RQ3
            end else begin
                ceiling = tlec_pkg::tlec_floor(cfg.fwd, cfg.mode); // RQ1 RQ3
            end
        end else if (run_rev && !run_fwd) begin
            if (release_active) begin
                ceiling = tlec_pkg::tlec_floor(cfg.rev_rel, cfg.mode); // RQ5 RQ3
            end else begin
                ceiling = tlec_pkg::tlec_floor(cfg.rev, cfg.mode); // RQ1 RQ3
            end
        end
    end

endmodule

// ==== verilog/tlec_torque_encoder_cfg.sv ====
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module tlec_torque_encoder_cfg #(
    parameter int BRAKE_UNIT_CYCLES = tlec_pkg::BRAKE_UNIT_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [7:0]             addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [31:0]                 rdata,
    input  wire logic                   run_fwd,
    input  wire logic                   run_rev,
    input  wire logic                   autotune_active,
    input  wire logic                   phase_found,
    input  wire logic                   phase_found_order,
    input  wire logic                   encoder_lost,
    input  wire logic                   fault_reset,
    output tlec_pkg::tlec_ceil_t        torque_ceiling,
    output logic                        release_phase,
    output tlec_pkg::tlec_mode_t        mode_sel,
    output tlec_pkg::tlec_enc_cfg_t     enc_cfg,
    output logic                        encoder_loss_error,
    output logic [7:0]                  error_code
);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    tlec_pkg::tlec_torque_cfg_t cfg;
    tlec_pkg::tlec_torque_cfg_t next_cfg;
    logic [15:0]                brake_time;
    logic [15:0]                next_brake_time;
    logic [13:0]                line_count;
    logic [13:0]                next_line_count;
    logic [2:0]                 kind;
    logic [2:0]                 next_kind;
    logic                       phase_order;
    logic                       next_phase_order;
    logic                       loss_en;
    logic                       next_loss_en;
    logic                       loss_flag;
    logic                       next_loss_flag;

    function automatic logic hit(input logic [7:0] a);
        return wr && addr == a;
    endfunction

    always_comb begin
        next_cfg         = cfg;
        next_brake_time  = brake_time;
        next_line_count  = line_count;
        next_kind        = kind;
        next_phase_order = phase_order;
        next_loss_en     = loss_en;
        next_loss_flag   = loss_flag;
        // out of range motor control and encoder kind selections are dropped rather than stored
        if (hit(tlec_pkg::ADDR_MOTOR_CONTROL_SELECT) && wdata <= 32'(tlec_pkg::MODE_VF)) begin
            next_cfg.mode = wdata[1:0]; // RQ12
        end
        if (hit(tlec_pkg::ADDR_FWD_CEILING)) begin
            next_cfg.fwd = tlec_pkg::tlec_clamp_ceiling(wdata); // RQ2
        end
        if (hit(tlec_pkg::ADDR_REV_CEILING)) begin
            next_cfg.rev = tlec_pkg::tlec_clamp_ceiling(wdata); // RQ2
        end
        if (hit(tlec_pkg::ADDR_FWD_REL_CEILING)) begin
            next_cfg.fwd_rel = tlec_pkg::tlec_clamp_ceiling(wdata); // RQ2
        end
        if (hit(tlec_pkg::ADDR_REV_REL_CEILING)) begin
            next_cfg.rev_rel = tlec_pkg::tlec_clamp_ceiling(wdata); // RQ2
        end
        if (hit(tlec_pkg::ADDR_BRAKE_CONTROL_SELECT)) begin
            next_cfg.brake_sel = wdata[2:0];
        end
        if (hit(tlec_pkg::ADDR_BRAKE_RELEASE_TIME)) begin
            next_brake_time = wdata[15:0];
        end
        // line count above the maximum saturates
        if (hit(tlec_pkg::ADDR_ENCODER_LINE_COUNT)) begin
            if (wdata > 32'(tlec_pkg::LINE_COUNT_MAX)) begin
                next_line_count = tlec_pkg::LINE_COUNT_MAX; // RQ6
            end else begin
                next_line_count = wdata[13:0]; // RQ6
            end
        end
        if (hit(tlec_pkg::ADDR_ENCODER_KIND_SELECT) && wdata <= 32'(tlec_pkg::KIND_MAX)) begin
            next_kind = wdata[2:0]; // RQ7
        end
        if (hit(tlec_pkg::ADDR_QUAD_PHASE_ORDER)) begin
            next_phase_order = wdata[0];
        end
        // the identified order overrides a software write in the same cycle
        if (autotune_active && phase_found) begin
            next_phase_order = phase_found_order; // RQ9
        end
        if (hit(tlec_pkg::ADDR_ENCODER_LOSS_CHECK)) begin
            next_loss_en = wdata[0];
        end
        // clear first, then set, so a loss in the clearing cycle survives
        if (fault_reset || (hit(tlec_pkg::ADDR_STATUS) && wdata[tlec_pkg::STAT_LOSS_BIT])) begin
            next_loss_flag = 1'b0; // RQ13
        end
        if (loss_en && encoder_lost) begin
            next_loss_flag = 1'b1; // RQ10 RQ13
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg.mode      <= tlec_pkg::MODE_SENSORLESS;
            cfg.brake_sel <= tlec_pkg::RST_BRAKE_SELECT;
            cfg.fwd       <= tlec_pkg::RST_FWD_CEIL;
            cfg.rev       <= tlec_pkg::RST_REV_CEIL;
            cfg.fwd_rel   <= tlec_pkg::RST_FWD_REL_CEIL;
            cfg.rev_rel   <= tlec_pkg::RST_REV_REL_CEIL;
            brake_time    <= tlec_pkg::RST_BRAKE_TIME;
            line_count    <= tlec_pkg::RST_LINE_COUNT;
            kind          <= tlec_pkg::KIND_QUADRATURE;
            phase_order   <= 1'b0;
            loss_en       <= 1'b1;
            loss_flag     <= 1'b0;
        end else begin
            cfg           <= next_cfg;
            brake_time    <= next_brake_time;
            line_count    <= next_line_count;
            kind          <= next_kind;
            phase_order   <= next_phase_order;
            loss_en       <= next_loss_en;
            loss_flag     <= next_loss_flag;
        end
    end

    // ------------------------------------------------------------
    // brake release timing
    // ------------------------------------------------------------
    // a start is a move from no run to exactly one direction
    logic        running;
    logic        running_q;
    logic        next_running_q;
    logic [17:0] prescale;
    logic [17:0] next_prescale;
    logic [15:0] rel_left;
    logic [15:0] next_rel_left;
    logic        rel_active;

    assign running    = run_fwd ^ run_rev;
    // the start cycle takes the release ceiling too, before the counter is loaded
    assign rel_active = running && cfg.brake_sel == tlec_pkg::BRAKE_MANUAL // RQ4
                        && (running_q ? rel_left != 16'h0000
                                      : brake_time != 16'h0000); // RQ5

    always_comb begin
        next_running_q = running;
        next_prescale  = prescale;
        next_rel_left  = rel_left;
        if (!running) begin
            next_rel_left = 16'h0000;
            next_prescale = '0;
        end else if (!running_q) begin
            next_rel_left = brake_time; // RQ5
            next_prescale = '0;
        end else if (rel_left != 16'h0000) begin
            if (prescale == 18'(BRAKE_UNIT_CYCLES - 1)) begin
                next_prescale = '0;
                next_rel_left = rel_left - 16'h0001;
            end else begin
                next_prescale = prescale + 18'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            running_q <= 1'b0;
            prescale  <= '0;
            rel_left  <= '0;
        end else begin
            running_q <= next_running_q;
            prescale  <= next_prescale;
            rel_left  <= next_rel_left;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    tlec_pkg::tlec_ceil_t    sel_ceiling;
    tlec_pkg::tlec_enc_cfg_t next_enc_cfg;
    tlec_pkg::tlec_mode_t    next_mode_sel;
    logic [31:0]             next_rdata;

    tlec_ceiling_sel u_sel (
        .cfg            (cfg),
        .run_fwd        (run_fwd),
        .run_rev        (run_rev),
        .release_active (rel_active),
        .ceiling        (sel_ceiling)
    );

    always_comb begin
        next_enc_cfg.line_count       = line_count;
        next_enc_cfg.kind_quadrature  = kind == tlec_pkg::KIND_QUADRATURE; // RQ7
        next_enc_cfg.kind_commutation = kind == tlec_pkg::KIND_COMMUTATION; // RQ7
        next_enc_cfg.kind_resolver    = kind == tlec_pkg::KIND_RESOLVER; // RQ7
        next_enc_cfg.kind_reserved    = kind > tlec_pkg::KIND_RESOLVER; // RQ7
        next_enc_cfg.phase_order      = phase_order
                                        && kind == tlec_pkg::KIND_QUADRATURE; // RQ8
        next_mode_sel.sensorless      = cfg.mode == tlec_pkg::MODE_SENSORLESS; // RQ12
        next_mode_sel.closed_loop     = cfg.mode == tlec_pkg::MODE_CLOSED_LOOP; // RQ12
        next_mode_sel.vf              = cfg.mode == tlec_pkg::MODE_VF; // RQ12
    end

    // unmapped addresses read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                tlec_pkg::ADDR_MOTOR_CONTROL_SELECT: next_rdata = 32'(cfg.mode);
                tlec_pkg::ADDR_FWD_CEILING:          next_rdata = 32'(cfg.fwd);
                tlec_pkg::ADDR_REV_CEILING:          next_rdata = 32'(cfg.rev);
                tlec_pkg::ADDR_FWD_REL_CEILING:      next_rdata = 32'(cfg.fwd_rel);
                tlec_pkg::ADDR_REV_REL_CEILING:      next_rdata = 32'(cfg.rev_rel);
                tlec_pkg::ADDR_BRAKE_CONTROL_SELECT: next_rdata = 32'(cfg.brake_sel);
                tlec_pkg::ADDR_BRAKE_RELEASE_TIME:   next_rdata = 32'(brake_time);
                tlec_pkg::ADDR_ENCODER_LINE_COUNT:   next_rdata = 32'(line_count);
                tlec_pkg::ADDR_ENCODER_KIND_SELECT:  next_rdata = 32'(kind);
                tlec_pkg::ADDR_QUAD_PHASE_ORDER:     next_rdata = 32'(phase_order);
                tlec_pkg::ADDR_ENCODER_LOSS_CHECK:   next_rdata = 32'(loss_en);
                tlec_pkg::ADDR_STATUS: begin
                    next_rdata[tlec_pkg::STAT_LOSS_BIT]    = loss_flag;
                    next_rdata[tlec_pkg::STAT_RELEASE_BIT] = rel_active;
                    next_rdata[tlec_pkg::STAT_PHASE_BIT]   = next_enc_cfg.phase_order;
                    next_rdata[tlec_pkg::STAT_CEIL_LSB +: 13] = torque_ceiling;
                end
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata              <= '0;
            torque_ceiling     <= '0;
            release_phase      <= 1'b0;
            mode_sel           <= '0;
            enc_cfg            <= '0;
            encoder_loss_error <= 1'b0;
            error_code         <= 8'h00;
        end else begin
            rdata              <= next_rdata;
            torque_ceiling     <= sel_ceiling;
            release_phase      <= rel_active;
            mode_sel           <= next_mode_sel;
            enc_cfg            <= next_enc_cfg;
            encoder_loss_error <= loss_flag;
            error_code         <= loss_flag ? tlec_pkg::ERR_ENCODER_LOSS : 8'h00; // RQ10
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_fwd_ceiling_pick: assert property ( // RQ1
        (run_fwd && !run_rev && !rel_active && cfg.mode != tlec_pkg::MODE_SENSORLESS)
        |=> torque_ceiling == $past(cfg.fwd))
        else $error("forward ceiling not applied");

    a_rev_ceiling_pick: assert property ( // RQ1
        (run_rev && !run_fwd && !rel_active && cfg.mode != tlec_pkg::MODE_SENSORLESS)
        |=> torque_ceiling == $past(cfg.rev))
        else $error("reverse ceiling not applied");

    a_ceiling_range: assert property ( // RQ2
        torque_ceiling <= tlec_pkg::CEIL_MAX && cfg.fwd <= tlec_pkg::CEIL_MAX)
        else $error("ceiling above maximum");

    a_svc_floor_hold: assert property ( // RQ3
        (running && cfg.mode == tlec_pkg::MODE_SENSORLESS)
        |=> torque_ceiling >= tlec_pkg::SVC_FLOOR)
        else $error("sensorless floor missing");

    a_release_manual_only: assert property ( // RQ4
        cfg.brake_sel != tlec_pkg::BRAKE_MANUAL |-> !rel_active ##1 !release_phase)
        else $error("release phase without manual brake");

    a_release_ceiling_use: assert property ( // RQ5
        (rel_active && run_fwd && cfg.mode != tlec_pkg::MODE_SENSORLESS)
        |=> torque_ceiling == $past(cfg.fwd_rel) && release_phase)
        else $error("release ceiling not applied");

    a_release_start_load: assert property ( // RQ5
        (running && !running_q && brake_time != 16'h0000 && !rst)
        |=> rel_left == $past(brake_time))
        else $error("release time not loaded at start");

    a_line_count_range: assert property ( // RQ6
        enc_cfg.line_count <= tlec_pkg::LINE_COUNT_MAX)
        else $error("line count above maximum");

    a_kind_decode: assert property ( // RQ7
        kind == tlec_pkg::KIND_RESOLVER |=> enc_cfg.kind_resolver && !enc_cfg.kind_quadrature)
        else $error("encoder kind decode wrong");

    a_phase_quad_only: assert property ( // RQ8
        kind != tlec_pkg::KIND_QUADRATURE |=> !enc_cfg.phase_order)
        else $error("phase order used for non quadrature");

    a_autotune_phase: assert property ( // RQ9
        (autotune_active && phase_found) |=> phase_order == $past(phase_found_order))
        else $error("identified phase order not stored");

    a_loss_report: assert property ( // RQ10
        (loss_en && encoder_lost) |=> ##1 (encoder_loss_error
                                           && error_code == tlec_pkg::ERR_ENCODER_LOSS))
        else $error("encoder loss not reported");

    a_loss_suppress: assert property ( // RQ10
        (!loss_en && !loss_flag) |=> !loss_flag)
        else $error("suppressed encoder loss reported");

    a_mode_decode: assert property ( // RQ12
        cfg.mode == tlec_pkg::MODE_CLOSED_LOOP |=> mode_sel.closed_loop && !mode_sel.sensorless)
        else $error("control mode decode wrong");

    a_loss_sticky: assert property ( // RQ13
        (loss_flag && !fault_reset && !hit(tlec_pkg::ADDR_STATUS)) |=> loss_flag)
        else $error("loss flag dropped without reset");

    c_release_used: cover property (rel_active ##1 release_phase);
    c_svc_floor: cover property (running && cfg.mode == tlec_pkg::MODE_SENSORLESS
                                 && cfg.fwd < tlec_pkg::SVC_FLOOR);
    c_autotune: cover property (autotune_active && phase_found);
    c_loss_clear: cover property (loss_flag ##1 fault_reset ##1 !loss_flag);

endmodule

// ==== verif/tlec_enc_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// feedback card model
// ------------------------------------------------------------
module tlec_enc_model (
    input  wire logic clk,
    input  wire logic cut,
    input  wire logic tune,
    input  wire logic order,
    output logic      encoder_lost = 1'b0,
    output logic      phase_found = 1'b0,
    output logic      phase_found_order = 1'b0
);
    logic tune_d = 1'b0;
    // the card filters a broken cable, so the loss shows one cycle late
    always_ff @(posedge clk) begin
        encoder_lost <= cut;
        tune_d <= tune;
        phase_found <= tune && !tune_d;
        // the order line only means something beside the pulse, so it toggles otherwise
        phase_found_order <= (tune && !tune_d) ? order : !phase_found_order;
    end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run_fwd = 1'b0, run_rev = 1'b0;
    logic tune = 1'b0, fault_reset = 1'b0, cut = 1'b0, ord = 1'b0, lost, pf, pfo, relp, lerr;
    logic [7:0] addr = 8'h00, ecode;
    logic [31:0] wdata = 32'h0, rdata, f, r;
    tlec_pkg::tlec_ceil_t ceil;
    tlec_pkg::tlec_mode_t msel;
    tlec_pkg::tlec_enc_cfg_t ecfg;
    int miscompares = 0, n_compared = 0;
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h20, 8'h24, 8'h28};
    logic [31:0] rv [9] = '{0, 1800, 1800, 1500, 1300, 1024, 0, 0, 1};
    always #2.5 clk = ~clk;
    tlec_torque_encoder_cfg #(.BRAKE_UNIT_CYCLES(4)) tlec_torque_encoder_cfg_i (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .run_fwd(run_fwd), .run_rev(run_rev), .autotune_active(tune), .phase_found(pf),
        .phase_found_order(pfo), .encoder_lost(lost), .fault_reset(fault_reset),
        .torque_ceiling(ceil), .release_phase(relp), .mode_sel(msel), .enc_cfg(ecfg),
        .encoder_loss_error(lerr), .error_code(ecode));
    tlec_enc_model tlec_enc_model_i (.clk(clk), .cut(cut), .tune(tune), .order(ord),
        .encoder_lost(lost), .phase_found(pf), .phase_found_order(pfo));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [31:0] exp_ceil(input logic [31:0] c, input int m);
        return (m == 0 && c < 500) ? 32'd500 : c;
    endfunction
    task automatic stop_test;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        stop_test();
    end
    initial begin
        void'($urandom(32'hd63b));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rd_reg(ra[i], rv[i]);
        wr_reg(8'h04, 32'd6000);
        rd_reg(8'h04, 32'd5000);
        wr_reg(8'h1c, 32'd9000);
        rd_reg(8'h1c, 32'd8192);
        wr_reg(8'h00, 32'd3);
        rd_reg(8'h00, 32'd0);
        wr_reg(8'h20, 32'd5);
        rd_reg(8'h20, 32'd0);
        for (int k = 0; k < 5; k++) begin
            wr_reg(8'h20, 32'(k));
            wr_reg(8'h24, 32'd1);
            if (k < 3) wr_reg(8'h00, 32'(k));
            wait_n(3);
            chk({ecfg.kind_quadrature, ecfg.kind_commutation, ecfg.kind_resolver,
                 ecfg.kind_reserved}, {k == 0, k == 1, k == 2, k > 2});
            chk(ecfg.phase_order, k == 0);
            if (k < 3) chk(msel, {k == 0, k == 1, k == 2});
        end
        wr_reg(8'h20, 32'd0);
        wr_reg(8'h1c, 32'd2048);
        for (int i = 0; i < 8; i++) begin
            f = (i == 0) ? 32'd400 : $urandom % 5001;
            r = (i == 1) ? 32'd499 : $urandom % 5001;
            wr_reg(8'h00, 32'(i % 2));
            wr_reg(8'h04, f);
            wr_reg(8'h08, r);
            @(posedge clk) run_fwd <= 1'b1;
            wait_n(3);
            chk(ceil, exp_ceil(f, i % 2));
            @(posedge clk) begin run_fwd <= 1'b0; run_rev <= 1'b1; end
            wait_n(3);
            chk(ceil, exp_ceil(r, i % 2));
            @(posedge clk) run_rev <= 1'b0;
        end
        wr_reg(8'h00, 32'd1);
        wr_reg(8'h04, 32'd2500);
        wr_reg(8'h18, 32'd1);
        for (int b = 2; b > 0; b--) begin
            wr_reg(8'h14, 32'(b));
            @(posedge clk) run_fwd <= 1'b1;
            wait_n(1);
            chk(ceil, (b == 2) ? 32'd1500 : 32'd2500);
            wait_n(2);
            chk(relp, b == 2);
            chk(ceil, (b == 2) ? 32'd1500 : 32'd2500);
            wait_n(12);
            chk({relp, ceil}, 32'd2500);
            @(posedge clk) run_fwd <= 1'b0;
        end
        for (int o = 1; o >= 0; o--) begin
            wr_reg(8'h24, 32'(1 - o));
            @(posedge clk) begin tune <= 1'b1; ord <= o[0]; end
            wait_n(4);
            rd_reg(8'h24, 32'(o));
            chk(ecfg.phase_order, o[0]);
            @(posedge clk) tune <= 1'b0;
        end
        @(posedge clk) cut <= 1'b1;
        wait_n(5);
        chk({lerr, ecode}, {1'b1, 8'h14});
        @(posedge clk) cut <= 1'b0;
        wait_n(4);
        chk({lerr, ecode}, {1'b1, 8'h14});
        rd_reg(8'h2c, 32'd1);
        @(posedge clk) fault_reset <= 1'b1;
        @(posedge clk) fault_reset <= 1'b0;
        wait_n(3);
        chk({lerr, ecode}, 32'd0);
        wr_reg(8'h28, 32'd0);
        @(posedge clk) cut <= 1'b1;
        wait_n(5);
        chk({lerr, ecode}, 32'd0);
        stop_test();
    end
endmodule
